/* include/fifo_threshold_turnaround_defs.vh */
// Constants for the threshold and line turn-around configuration block
//
// Operation
// - Transmit FIFO interrupt trigger level is 8 bits, one to 128, step one.
// - Receive FIFO interrupt trigger level is 8 bits, one to 128, step one.
// - Stored zero or one means level one; larger N up to 0x80 means N.
// - High receive fill threshold tells the remote sender to stop.
// - Low receive fill threshold tells the remote sender it may resume.
// - The four threshold registers apply only in 128-byte FIFO mode.
// - Prescaler is 4 bits in the low nibble, upper nibble reserved, reset 0.
// - Turn-around delay is 8 bits, counted in bit periods, not clocks.
// - After the last bit leaves the shifter, load delay, count down per bit.
// - At count zero the selected direction pin is driven to logic 0.
// - In multidrop mode RTS or DTR steers external transceiver direction; here only with i_transmitter_drives_direction_pin also set.
// - Direction control only with multidrop enable set; else plain port.
// - Direction pin select one uses DTR, zero uses RTS.
// - Transmit interrupt when TX content below trigger level or FIFO empty.
`ifndef FIFO_THRESHOLD_TURNAROUND_DEFS_VH
`define FIFO_THRESHOLD_TURNAROUND_DEFS_VH

// Register addresses on the local register port
`define ADDR_TX_FIFO_IRQ_LEVEL 3'h0
`define ADDR_RX_FIFO_IRQ_LEVEL 3'h1
`define ADDR_FLOW_HIGH_THRESHOLD 3'h2
`define ADDR_FLOW_LOW_THRESHOLD 3'h3
`define ADDR_CLOCK_PRESCALE_VALUE 3'h4
`define ADDR_LINE_TURNAROUND_DELAY 3'h5
`define ADDR_DIRECTION_STATUS 3'h6

// Reset values
`define RST_TX_FIFO_IRQ_LEVEL 8'h00
`define RST_RX_FIFO_IRQ_LEVEL 8'h00
`define RST_FLOW_HIGH_THRESHOLD 8'h00
`define RST_FLOW_LOW_THRESHOLD 8'h00
`define RST_CLOCK_PRESCALE_VALUE 4'h0
`define RST_LINE_TURNAROUND_DELAY 8'h00

// Field layout of the prescaler register
`define PRESCALE_MSB 3
`define PRESCALE_LSB 0

// Level encoding
`define LEVEL_MIN 8'h01
`define LEVEL_MAX 8'h80

// Last oversampling phase of a bit period; 16 ticks per bit
`define TICKS_PER_BIT 4'hf

`endif

/* hw/fifo_level_compare.v */
// Threshold decode and FIFO fill comparison
`timescale 1ns/10ps
`default_nettype none
`include "fifo_threshold_turnaround_defs.vh"
module fifo_level_compare (
  input wire [7:0] i_level_raw,
  input wire [7:0] i_fill_count,
  output wire o_at_or_above,
  output wire [7:0] o_level
);

  // Zero and one both mean one entry; cap at the 128 entry FIFO
  function [7:0] effective_level;
    input [7:0] raw;
    begin
      if (raw < `LEVEL_MIN) begin
        effective_level = `LEVEL_MIN;
      end else if (raw > `LEVEL_MAX) begin
        effective_level = `LEVEL_MAX;
      end else begin
        effective_level = raw;
      end
    end
  endfunction

  // Pure comparison; the caller registers the result
  assign o_level = effective_level(i_level_raw);
  assign o_at_or_above = (i_fill_count >= o_level);

endmodule // fifo_level_compare

`default_nettype wire

/* hw/bit_period_tick.v */
// Divides the oversampling enable down to one pulse per bit period
`timescale 1ns/10ps
`default_nettype none
`include "fifo_threshold_turnaround_defs.vh"
module bit_period_tick (
  input wire i_sys_clk,
  input wire i_reset_n,
  input wire i_clear,
  input wire i_tick16,
  output reg o_bit_tick
);

  reg [3:0] phase;

  // Clear realigns the bit boundary to the end of the last stop bit
  always @(posedge i_sys_clk) begin
    if (!i_reset_n || i_clear) begin
      phase <= 4'h0;
      o_bit_tick <= 1'b0;
    end else begin
      o_bit_tick <= 1'b0;
      if (i_tick16) begin
        if (phase == `TICKS_PER_BIT) begin
          phase <= 4'h0;
          o_bit_tick <= 1'b1;
        end else begin
          phase <= phase + 4'h1;
        end
      end
    end
  end

endmodule // bit_period_tick

`default_nettype wire

/* hw/fifo_threshold_turnaround_cfg.v */
// Threshold registers and RS-485 line turn-around countdown
`timescale 1ns/10ps
`default_nettype none
`include "fifo_threshold_turnaround_defs.vh"
module fifo_threshold_turnaround_cfg (
  input wire i_sys_clk,
  input wire i_reset_n,
  // Local register port
  input wire i_reg_wr_en,
  input wire [2:0] i_reg_addr,
  input wire [7:0] i_reg_wr_data,
  output reg [7:0] o_reg_rd_data,
  // Mode controls from the rest of the UART
  input wire i_fifo128_mode,
  input wire i_multidrop_mode_enable,
  input wire i_direction_pin_select,
  input wire i_transmitter_drives_direction_pin,
  input wire i_tx_empty_irq_mode,
  // Levels used in 32-byte FIFO mode
  input wire [7:0] i_alt_tx_level,
  input wire [7:0] i_alt_rx_level,
  input wire [7:0] i_alt_flow_high,
  input wire [7:0] i_alt_flow_low,
  // FIFO and transmitter state
  input wire [7:0] i_tx_fifo_count,
  input wire [7:0] i_rx_fifo_count,
  input wire i_tx_start,
  input wire i_tx_shift_done,
  input wire i_baud_tick16,
  // Modem outputs as the modem control logic wants them
  input wire i_rts_normal,
  input wire i_dtr_normal,
  // Outputs
  output reg o_tx_irq,
  output reg o_rx_irq,
  output reg o_flow_stop,
  output reg o_flow_resume,
  output reg [3:0] o_clock_prescale,
  output reg o_rts_pin,
  output reg o_dtr_pin,
  output reg o_turnaround_busy
);

  // Direction states
  localparam [1:0] DIR_RECEIVE = 2'b00;
  localparam [1:0] DIR_TRANSMIT = 2'b01;
  localparam [1:0] DIR_COUNTDOWN = 2'b10;

  reg [7:0] tx_fifo_irq_level;
  reg [7:0] rx_fifo_irq_level;
  reg [7:0] flow_high_threshold;
  reg [7:0] flow_low_threshold;
  reg [3:0] clock_prescale_value;
  reg [7:0] line_turnaround_delay;
  reg [1:0] dir_state;
  reg [1:0] next_dir_state;
  reg [7:0] turn_count;
  reg [7:0] next_turn_count;
  reg bit_clear;
  reg tx_was_empty;
  wire bit_tick;
  wire tx_ge;
  wire rx_ge;
  wire high_ge;
  wire low_ge;
  wire [7:0] sel_tx;
  wire [7:0] sel_rx;
  wire [7:0] sel_high;
  wire [7:0] sel_low;
  wire tx_empty_now;
  wire auto_dir;
  wire dir_level;

  // Register writes; prescaler keeps only its low nibble
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tx_fifo_irq_level <= `RST_TX_FIFO_IRQ_LEVEL;
      rx_fifo_irq_level <= `RST_RX_FIFO_IRQ_LEVEL;
      flow_high_threshold <= `RST_FLOW_HIGH_THRESHOLD;
      flow_low_threshold <= `RST_FLOW_LOW_THRESHOLD;
      clock_prescale_value <= `RST_CLOCK_PRESCALE_VALUE;
      line_turnaround_delay <= `RST_LINE_TURNAROUND_DELAY;
    end else if (i_reg_wr_en) begin
      case (i_reg_addr)
        `ADDR_TX_FIFO_IRQ_LEVEL: begin
          tx_fifo_irq_level <= i_reg_wr_data;
        end
        `ADDR_RX_FIFO_IRQ_LEVEL: begin
          rx_fifo_irq_level <= i_reg_wr_data;
        end
        `ADDR_FLOW_HIGH_THRESHOLD: begin
          flow_high_threshold <= i_reg_wr_data;
        end
        `ADDR_FLOW_LOW_THRESHOLD: begin
          flow_low_threshold <= i_reg_wr_data;
        end
        `ADDR_CLOCK_PRESCALE_VALUE: begin
          clock_prescale_value <=
            i_reg_wr_data[`PRESCALE_MSB:`PRESCALE_LSB];
        end
        `ADDR_LINE_TURNAROUND_DELAY: begin
          line_turnaround_delay <= i_reg_wr_data;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data registered one cycle after the address; unmapped reads zero
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_reg_rd_data <= 8'h00;
    end else begin
      case (i_reg_addr)
        `ADDR_TX_FIFO_IRQ_LEVEL: o_reg_rd_data <= tx_fifo_irq_level;
        `ADDR_RX_FIFO_IRQ_LEVEL: o_reg_rd_data <= rx_fifo_irq_level;
        `ADDR_FLOW_HIGH_THRESHOLD: o_reg_rd_data <= flow_high_threshold;
        `ADDR_FLOW_LOW_THRESHOLD: o_reg_rd_data <= flow_low_threshold;
        `ADDR_CLOCK_PRESCALE_VALUE: begin
          o_reg_rd_data <= {4'h0, clock_prescale_value};
        end
        `ADDR_LINE_TURNAROUND_DELAY: o_reg_rd_data <= line_turnaround_delay;
        `ADDR_DIRECTION_STATUS: begin
          o_reg_rd_data <= {6'h00, dir_state};
        end
        default: o_reg_rd_data <= 8'h00;
      endcase
    end
  end

  // Same source choice for all four thresholds
  function [7:0] pick_level;
    input use_prog;
    input [7:0] prog;
    input [7:0] alt;
    begin
      pick_level = use_prog ? prog : alt;
    end
  endfunction

  // Programmed thresholds only count in 128-byte mode
  assign sel_tx = pick_level(i_fifo128_mode, tx_fifo_irq_level,
    i_alt_tx_level);
  assign sel_rx = pick_level(i_fifo128_mode, rx_fifo_irq_level,
    i_alt_rx_level);
  assign sel_high = pick_level(i_fifo128_mode, flow_high_threshold,
    i_alt_flow_high);
  assign sel_low = pick_level(i_fifo128_mode, flow_low_threshold,
    i_alt_flow_low);

  // Decoded levels stay open; only the comparison is used here
  fifo_level_compare u_tx_cmp (
    .i_level_raw(sel_tx),
    .i_fill_count(i_tx_fifo_count),
    .o_at_or_above(tx_ge),
    .o_level()
  );

  fifo_level_compare u_rx_cmp (
    .i_level_raw(sel_rx),
    .i_fill_count(i_rx_fifo_count),
    .o_at_or_above(rx_ge),
    .o_level()
  );

  fifo_level_compare u_high_cmp (
    .i_level_raw(sel_high),
    .i_fill_count(i_rx_fifo_count),
    .o_at_or_above(high_ge),
    .o_level()
  );

  fifo_level_compare u_low_cmp (
    .i_level_raw(sel_low),
    .i_fill_count(i_rx_fifo_count),
    .o_at_or_above(low_ge),
    .o_level()
  );

  // Empty alone, or empty and shifter drained in the stricter mode
  assign tx_empty_now = (i_tx_fifo_count == 8'h00) &&
    (!i_tx_empty_irq_mode || tx_was_empty);

  // Remembers that the last stop bit has left since the FIFO emptied
  // New data wins over a simultaneous stop bit: the shifter reloads
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      tx_was_empty <= 1'b1;
    end else if (i_tx_start) begin
      tx_was_empty <= 1'b0;
    end else if (i_tx_shift_done) begin
      tx_was_empty <= 1'b1;
    end
  end

  // Threshold outputs; high wins over resume so both never stand together
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_tx_irq <= 1'b0;
      o_rx_irq <= 1'b0;
      o_flow_stop <= 1'b0;
      o_flow_resume <= 1'b0;
      o_clock_prescale <= `RST_CLOCK_PRESCALE_VALUE;
    end else begin
      o_tx_irq <= !tx_ge || tx_empty_now;
      o_rx_irq <= rx_ge;
      o_flow_stop <= high_ge;
      o_flow_resume <= !high_ge && !low_ge;
      o_clock_prescale <= clock_prescale_value;
    end
  end

  assign auto_dir = i_multidrop_mode_enable &&
    i_transmitter_drives_direction_pin;

  // Divider restarts at load so the first bit period is a whole one
  bit_period_tick u_bit_tick (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_clear(bit_clear),
    .i_tick16(i_baud_tick16),
    .o_bit_tick(bit_tick)
  );

  // Direction state machine; new data always wins over the countdown
  // A zero delay turns the line round on the last stop bit itself
  always @* begin
    next_dir_state = dir_state;
    next_turn_count = turn_count;
    bit_clear = 1'b0;
    if (!auto_dir) begin
      next_dir_state = DIR_RECEIVE;
      next_turn_count = 8'h00;
    end else if (i_tx_start) begin
      next_dir_state = DIR_TRANSMIT;
      next_turn_count = 8'h00;
    end else begin
      case (dir_state)
        DIR_RECEIVE: begin
        end
        DIR_TRANSMIT: begin
          if (i_tx_shift_done && i_tx_fifo_count == 8'h00) begin
            bit_clear = 1'b1;
            next_turn_count = line_turnaround_delay;
            if (line_turnaround_delay == 8'h00) begin
              next_dir_state = DIR_RECEIVE;
            end else begin
              next_dir_state = DIR_COUNTDOWN;
            end
          end
        end
        DIR_COUNTDOWN: begin
          if (bit_tick) begin
            next_turn_count = turn_count - 8'h01;
            if (turn_count == 8'h01) begin
              next_dir_state = DIR_RECEIVE;
            end
          end
        end
        default: begin
          next_dir_state = DIR_RECEIVE;
        end
      endcase
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      dir_state <= DIR_RECEIVE;
      turn_count <= 8'h00;
    end else begin
      dir_state <= next_dir_state;
      turn_count <= next_turn_count;
    end
  end

  // Pin high while sending, low once turned round for receiving
  assign dir_level = (next_dir_state != DIR_RECEIVE);

  // Selected pin carries direction; the other keeps its modem role
  // Reset leaves both pins high, the idle level of the modem lines
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      o_rts_pin <= 1'b1;
      o_dtr_pin <= 1'b1;
      o_turnaround_busy <= 1'b0;
    end else begin
      o_turnaround_busy <= (next_dir_state == DIR_COUNTDOWN);
      if (auto_dir && i_direction_pin_select) begin
        o_dtr_pin <= dir_level;
        o_rts_pin <= i_rts_normal;
      end else if (auto_dir) begin
        o_rts_pin <= dir_level;
        o_dtr_pin <= i_dtr_normal;
      end else begin
        o_rts_pin <= i_rts_normal;
        o_dtr_pin <= i_dtr_normal;
      end
    end
  end

endmodule // fifo_threshold_turnaround_cfg

`default_nettype wire

/* testbench/line_transceiver.sv */
// Direction input of an external line transceiver
`timescale 1ns/10ps
`default_nettype none
module line_transceiver (
  input wire logic i_dir,
  output logic o_driver_on,
  output logic o_receiver_on
);
  // High drives the line, low listens; unknown does neither
  assign o_driver_on = (i_dir === 1'b1);
  assign o_receiver_on = (i_dir === 1'b0);
endmodule // line_transceiver
`default_nettype wire

/* testbench/cfg_monitor.sv */
// Port checker for the threshold and turn-around block
`timescale 1ns/10ps
`default_nettype none
module cfg_monitor (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr_en,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wr_data,
  input wire logic i_fifo128_mode,
  input wire logic i_multidrop_mode_enable,
  input wire logic i_direction_pin_select,
  input wire logic i_transmitter_drives_direction_pin,
  input wire logic [7:0] i_rx_fifo_count,
  input wire logic [7:0] i_tx_fifo_count,
  input wire logic i_tx_start,
  input wire logic i_tx_shift_done,
  input wire logic i_rts_normal,
  input wire logic o_rx_irq,
  input wire logic [3:0] o_clock_prescale,
  input wire logic o_rts_pin,
  input wire logic o_dtr_pin,
  input wire logic o_turnaround_busy
);
  logic [7:0] rx_lvl;
  logic [7:0] dly;
  wire auto_dir;
  wire sel_pin;
  // Mode decode and the pin that steers the transceiver
  assign auto_dir = i_multidrop_mode_enable &
    i_transmitter_drives_direction_pin;
  assign sel_pin = i_direction_pin_select ? o_dtr_pin : o_rts_pin;
  // Shadow of written values, so checks need no internal probes
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      rx_lvl <= 8'h00;
      dly <= 8'h00;
    end else if (i_reg_wr_en && i_reg_addr == 3'h1) begin
      rx_lvl <= i_reg_wr_data;
    end else if (i_reg_wr_en && i_reg_addr == 3'h5) begin
      dly <= i_reg_wr_data;
    end
  end
  function automatic logic [7:0] eff(input logic [7:0] raw);
    eff = (raw < 8'h02) ? 8'h01 : ((raw > 8'h80) ? 8'h80 : raw);
  endfunction
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_start;
    auto_dir && i_tx_start;
  endsequence
  sequence s_load;
    auto_dir && i_tx_shift_done && !i_tx_start && i_tx_fifo_count == 8'h00
      && sel_pin && !o_turnaround_busy;
  endsequence
  a_rx_irq_level: assert property (
    $past(i_reset_n && i_fifo128_mode) |->
    o_rx_irq == $past(i_rx_fifo_count >= eff(rx_lvl)))
    else $error("rx irq level wrong");
  a_prescale_write: assert property (
    i_reg_wr_en && i_reg_addr == 3'h4 |=> ##1
    o_clock_prescale == $past(i_reg_wr_data[3:0], 2))
    else $error("prescale not stored");
  a_start_drives: assert property (
    s_start |=> sel_pin && !o_turnaround_busy)
    else $error("start did not drive line");
  a_zero_delay: assert property (
    s_load ##0 dly == 8'h00 |=> !sel_pin)
    else $error("zero delay not immediate");
  a_load_holds: assert property (
    s_load ##0 dly != 8'h00 |=> o_turnaround_busy ##0 sel_pin [*8])
    else $error("countdown ended early");
  a_count_end: assert property (
    $fell(o_turnaround_busy) && !$past(i_tx_start) && auto_dir |->
    ##[0:1] !sel_pin) else $error("pin not low at end");
  a_other_pin: assert property (
    $past(i_reset_n && auto_dir && i_direction_pin_select) |->
    o_rts_pin == $past(i_rts_normal)) else $error("rts not normal");
  a_plain_port: assert property (
    $past(i_reset_n && !i_multidrop_mode_enable) |->
    o_rts_pin == $past(i_rts_normal)) else $error("plain rts wrong");
endmodule // cfg_monitor
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the threshold and turn-around block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdat = 8'h00;
  logic f128 = 1'b1;
  logic md = 1'b0;
  logic sel = 1'b0;
  logic [7:0] alt = 8'h05;
  logic [7:0] txc = 8'h00;
  logic [7:0] rxc = 8'h00;
  logic start = 1'b0;
  logic done = 1'b0;
  logic tick = 1'b0;
  logic rts_in = 1'b1;
  logic dtr_in = 1'b1;
  logic own = 1'b1;
  wire [7:0] rdat;
  wire [3:0] pres;
  wire tx_irq, rx_irq, stop, resume, rts, dtr, busy, drv_on, rcv_on;
  int n_mismatch = 0;
  int tests_run = 0;
  fifo_threshold_turnaround_cfg u_dut (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_reg_wr_en(wr), .i_reg_addr(addr), .i_reg_wr_data(wdat),
    .o_reg_rd_data(rdat), .i_fifo128_mode(f128), .i_multidrop_mode_enable(md),
    .i_direction_pin_select(sel), .i_transmitter_drives_direction_pin(own),
    .i_tx_empty_irq_mode(1'b0), .i_alt_tx_level(alt), .i_alt_rx_level(alt),
    .i_alt_flow_high(alt), .i_alt_flow_low(alt), .i_tx_fifo_count(txc),
    .i_rx_fifo_count(rxc), .i_tx_start(start), .i_tx_shift_done(done),
    .i_baud_tick16(tick), .i_rts_normal(rts_in), .i_dtr_normal(dtr_in),
    .o_tx_irq(tx_irq), .o_rx_irq(rx_irq), .o_flow_stop(stop),
    .o_flow_resume(resume), .o_clock_prescale(pres), .o_rts_pin(rts),
    .o_dtr_pin(dtr), .o_turnaround_busy(busy));
  line_transceiver u_xcvr (.i_dir(sel ? dtr : rts), .o_driver_on(drv_on),
    .o_receiver_on(rcv_on));
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk_bit(logic got, logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: byte %h want %h", $time, got, exp);
    end
  endtask
  // Strobe drops for a cycle so back-to-back calls never collide
  task automatic wr_reg(logic [2:0] a, logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdat = d;
    step();
    wr = 1'b0;
    step();
  endtask
  task automatic rd_chk(logic [2:0] a, logic [7:0] exp);
    addr = a;
    step();
    chk_byte(rdat, exp);
  endtask
  task automatic pulse_start();
    start = 1'b1;
    step();
    start = 1'b0;
    step();
  endtask
  task automatic pulse_done();
    done = 1'b1;
    step();
    done = 1'b0;
  endtask
  task automatic ticks(int n);
    repeat (n) begin
      tick = 1'b1;
      step();
      tick = 1'b0;
      step();
    end
  endtask
  task automatic t_regs();
    rd_chk(3'h4, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr_reg(i[2:0], 8'ha5 + i[7:0]);
      rd_chk(i[2:0], (i == 4) ? 8'h09 : 8'ha5 + i[7:0]);
    end
    chk_byte({4'h0, pres}, 8'h09);
    wr_reg(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00);
  endtask
  // Each level one below and at the threshold, all four registers
  task automatic t_levels();
    logic [7:0] raw [4] = '{8'h00, 8'h01, 8'h40, 8'h80};
    logic [7:0] lv;
    for (int k = 0; k < 4; k++) begin
      for (int a = 0; a < 4; a++) wr_reg(a[2:0], raw[k]);
      lv = (raw[k] < 8'h02) ? 8'h01 : raw[k];
      for (int b = 0; b < 2; b++) begin
        txc = lv - 8'h01 + b[7:0];
        rxc = txc;
        step(2);
        chk_bit(rx_irq, b[0]);
        chk_bit(stop, b[0]);
        chk_bit(resume, !b[0]);
        chk_bit(tx_irq, !b[0]);
      end
    end
    wr_reg(3'h3, 8'h10);
    rxc = 8'h20;
    step(2);
    chk_bit(resume, 1'b0);
    chk_bit(stop, 1'b0);
    rxc = 8'h0f;
    step(2);
    chk_bit(resume, 1'b1);
    f128 = 1'b0;
    rxc = 8'h05;
    step(2);
    chk_bit(rx_irq, 1'b1);
    f128 = 1'b1;
    step(2);
    chk_bit(rx_irq, 1'b0);
    txc = 8'h00;
    rxc = 8'h00;
  endtask
  // Two bit periods of countdown; the other pin follows modem logic
  task automatic t_turn(logic s);
    md = 1'b1;
    sel = s;
    rts_in = 1'b0;
    dtr_in = 1'b0;
    wr_reg(3'h5, 8'h02);
    pulse_start();
    chk_bit(drv_on, 1'b1);
    chk_bit(s ? rts : dtr, 1'b0);
    pulse_done();
    ticks(31);
    chk_bit(busy, 1'b1);
    chk_bit(drv_on, 1'b1);
    rd_chk(3'h6, 8'h02);
    ticks(1);
    step(2);
    chk_bit(rcv_on, 1'b1);
    chk_bit(busy, 1'b0);
    rd_chk(3'h6, 8'h00);
    rts_in = 1'b1;
    dtr_in = 1'b1;
  endtask
  task automatic t_abandon();
    wr_reg(3'h5, 8'h03);
    pulse_start();
    pulse_done();
    ticks(20);
    pulse_start();
    chk_bit(busy, 1'b0);
    rd_chk(3'h6, 8'h01);
    ticks(50);
    chk_bit(drv_on, 1'b1);
    wr_reg(3'h5, 8'h00);
    pulse_done();
    step();
    chk_bit(rcv_on, 1'b1);
  endtask
  task automatic t_plain();
    md = 1'b0;
    rts_in = 1'b0;
    pulse_start();
    chk_bit(rts, 1'b0);
    chk_bit(dtr, 1'b1);
    rts_in = 1'b1;
    dtr_in = 1'b0;
    step(2);
    chk_bit(rts, 1'b1);
    chk_bit(dtr, 1'b0);
    md = 1'b1;
    own = 1'b0;
    pulse_start();
    chk_bit(dtr, 1'b0);
    chk_bit(rts, 1'b1);
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    step(12);
    rst_n = 1'b1;
    t_regs();
    t_levels();
    t_turn(1'b0);
    t_turn(1'b1);
    t_abandon();
    t_plain();
    end_of_test();
  end
  // Watchdog, well past the few hundred cycles the run needs
  initial begin
    #500000;
    n_mismatch++;
    end_of_test();
  end
endmodule // tb
bind fifo_threshold_turnaround_cfg cfg_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n), .i_reg_wr_en(i_reg_wr_en), .i_reg_addr(i_reg_addr),
  .i_reg_wr_data(i_reg_wr_data), .i_fifo128_mode(i_fifo128_mode),
  .i_multidrop_mode_enable(i_multidrop_mode_enable),
  .i_direction_pin_select(i_direction_pin_select),
  .i_transmitter_drives_direction_pin(i_transmitter_drives_direction_pin),
  .i_rx_fifo_count(i_rx_fifo_count), .i_tx_fifo_count(i_tx_fifo_count),
  .i_tx_start(i_tx_start), .i_tx_shift_done(i_tx_shift_done),
  .i_rts_normal(i_rts_normal), .o_rx_irq(o_rx_irq),
  .o_clock_prescale(o_clock_prescale), .o_rts_pin(o_rts_pin),
  .o_dtr_pin(o_dtr_pin), .o_turnaround_busy(o_turnaround_busy));
`default_nettype wire
